/* File: logic/rhc_consts.svh */
// Constants of the rheostat command and fuse-memory controller.
// Assumes it is included by bare name from files under logic/.
`ifndef RHC_CONSTS_SVH
`define RHC_CONSTS_SVH
`define RH_WIPER_BITS 10
`define RH_MIDSCALE   10'h200
`define RH_MEM_FIRST  6'h01
`define RH_MEM_LAST   6'h32
`define RH_MEM_AW     6
`define RH_MEM_DEPTH  64
`define RH_FUSE_MS    350
`define RH_CLK_KHZ    50000
`define RH_CNT_W      25
`define RH_CTRL_W     4
`define RH_C_PROG_EN  0
`define RH_C_UNPROT   1
`define RH_C_CAL_DIS  2
`define RH_C_FUSE_OK  3
`define RH_SD_BIT     0
`endif

/* File: logic/rhc_pkg.sv */
// Types shared by the rheostat command controller files.
// Assumes rhc_consts.svh sits beside it.
`include "rhc_consts.svh"
package rhc_pkg;
  typedef enum logic [3:0] {
    OP_NOP      = 4'h0,
    OP_WIPER_WR = 4'h1,
    OP_WIPER_RD = 4'h2,
    OP_STORE    = 4'h3,
    OP_REFRESH  = 4'h4,
    OP_MEM_RD   = 4'h5,
    OP_LAST_RD  = 4'h6,
    OP_CTRL_WR  = 4'h7,
    OP_CTRL_RD  = 4'h8,
    OP_SHUTDOWN = 4'h9
  } rhc_op_e;

  typedef enum logic [2:0] {
    ST_BOOT = 3'b000,
    ST_RD1  = 3'b001,
    ST_RD2  = 3'b010,
    ST_IDLE = 3'b011,
    ST_FUSE = 3'b100
  } rhc_state_e;

  // Command word as it arrives in one frame
  typedef struct packed {
    logic [1:0] spare;
    logic [3:0] opcode;
    logic [9:0] data;
  } rhc_cmd_s;

  typedef struct packed {
    rhc_state_e                  state;
    logic                        cmd_s1;
    logic                        cmd_s2;
    logic                        cmd_seen;
    logic                        pin_s1;
    logic                        pin_s2;
    logic                        pin_prev;
    logic                        pin_pend;
    logic [9:0]                  wiper;
    logic [`RH_CTRL_W-1:0]       ctrl;
    logic                        shutdown;
    logic [`RH_MEM_AW-1:0]       last;
    logic [`RH_MEM_AW-1:0]       addr;
    logic                        we;
    logic [9:0]                  wdata;
    logic                        rd_refresh;
    logic [`RH_CNT_W-1:0]        cnt;
    logic [15:0]                 resp;
    logic                        resp_tgl;
    logic                        busy;
  } rhc_core_s;

  typedef struct packed {
    logic     cmd_tgl;
    rhc_cmd_s cmd_word;
    logic [15:0] resp_word;
    logic     rsp_s1;
    logic     rsp_s2;
    logic     rsp_seen;
    logic     ack_s1;
    logic     ack_s2;
  } rhc_link_s;
endpackage

/* File: logic/rhc_otp_mem.sv */
// Fuse-programmable wiper memory array, one shared address port.
// Assumes the controller writes each location once; read data are registered.
`timescale 1ns/1ps
module rhc_otp_mem #(
  parameter int unsigned DW    = 10,
  parameter int unsigned AW    = 6,
  parameter int unsigned DEPTH = 64
) (
  input  wire logic          clock,
  input  wire logic          rst_n,
  input  wire logic          ce,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata_r
);
  // Array is not reset: it models nonvolatile cells
  logic [DW-1:0] cells [DEPTH];

  always_ff @(posedge clock) begin
    if (ce && we) begin
      cells[addr] <= wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= '0;
    end else if (ce) begin
      rdata_r <= cells[addr];
    end
  end
endmodule

/* File: logic/rhc_core.sv */
// Command interpreter and fuse-memory control of a digital rheostat.
// Assumes a link-side framer on link_clk delivering one 16-bit word per frame.
`timescale 1ns/1ps
`include "rhc_consts.svh"
module rhc_core #(
  parameter int unsigned WIPER_BITS  = `RH_WIPER_BITS,
  parameter int unsigned FUSE_CYCLES = `RH_FUSE_MS * `RH_CLK_KHZ
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              ce,
  input  wire logic              rst_pin_n,
  input  wire logic              link_clk,
  input  wire logic              link_cmd_valid,
  input  wire rhc_pkg::rhc_cmd_s link_cmd_word,
  output logic [15:0]            link_resp_word,
  output logic                   link_ack_en,
  output logic [9:0]             wiper_register,
  output logic                   tolerance_cal_disable,
  output logic                   shutdown_active,
  output logic [9:0]             control_flags
);
  localparam rhc_pkg::rhc_core_s CORE_RST = '{state: rhc_pkg::ST_BOOT, wiper: `RH_MIDSCALE, pin_s1: 1'b1,
                                             pin_s2: 1'b1, pin_prev: 1'b1, default: '0};
  localparam rhc_pkg::rhc_link_s LINK_RST = '{ack_s1: 1'b1, ack_s2: 1'b1, default: '0};
  localparam logic [`RH_CNT_W-1:0] FUSE_LOAD = `RH_CNT_W'(FUSE_CYCLES - 1);

  rhc_pkg::rhc_core_s r;
  rhc_pkg::rhc_core_s n;
  rhc_pkg::rhc_link_s l;
  rhc_pkg::rhc_link_s ln;
  rhc_pkg::rhc_cmd_s  cw;
  logic [9:0]         mem_q;
  logic               cmd_new;
  logic               pin_fall;
  logic               cmd_go;

  function automatic logic [9:0] wiper_fit(input logic [9:0] d);
    wiper_fit = (WIPER_BITS == 8) ? {d[9:2], 2'b00} : d;
  endfunction

  rhc_otp_mem #(
    .DW    (`RH_WIPER_BITS),
    .AW    (`RH_MEM_AW),
    .DEPTH (`RH_MEM_DEPTH)
  ) u_mem (
    .clock   (clock),
    .rst_n   (rst_n),
    .ce      (ce),
    .we      (r.we),
    .addr    (r.addr),
    .wdata   (r.wdata),
    .rdata_r (mem_q)
  );

  // Word is held stable by the link side until the next toggle, so it is read directly
  assign cw       = l.cmd_word;
  assign cmd_new  = r.cmd_s2 != r.cmd_seen;
  assign pin_fall = r.pin_prev && !r.pin_s2;
  assign cmd_go   = (r.state == rhc_pkg::ST_IDLE) && cmd_new && !r.pin_pend;

  always_comb begin
    n        = r;
    n.cmd_s1 = l.cmd_tgl;
    n.cmd_s2 = r.cmd_s1;
    n.pin_s1 = rst_pin_n;
    n.pin_s2 = r.pin_s1;
    n.pin_prev = r.pin_s2;
    n.we     = 1'b0;
    case (r.state)
      rhc_pkg::ST_BOOT: begin
        n.addr       = r.last;
        n.rd_refresh = 1'b1;
        n.state      = rhc_pkg::ST_RD1;
      end
      rhc_pkg::ST_RD1: begin
        n.state = rhc_pkg::ST_RD2;
      end
      rhc_pkg::ST_RD2: begin
        if (r.rd_refresh) begin
          n.wiper = (r.last == '0) ? `RH_MIDSCALE : mem_q;
        end else begin
          n.resp     = {6'h00, mem_q};
          n.resp_tgl = ~r.resp_tgl;
        end
        n.state = rhc_pkg::ST_IDLE;
      end
      rhc_pkg::ST_FUSE: begin
        // Words reaching us while the fuse burns are dropped
        if (cmd_new) begin
          n.cmd_seen = r.cmd_s2;
        end
        if (r.cnt == '0) begin
          n.ctrl[`RH_C_FUSE_OK] = 1'b1;
          n.busy  = 1'b0;
          n.state = rhc_pkg::ST_IDLE;
        end else begin
          n.cnt = r.cnt - 1'b1;
        end
      end
      rhc_pkg::ST_IDLE: begin
        if (r.pin_pend) begin
          n.pin_pend = 1'b0;
          n.shutdown = 1'b0;
          n.state    = rhc_pkg::ST_BOOT;
        end else if (cmd_new) begin
          n.cmd_seen = r.cmd_s2;
          // Non-read words echo themselves in the next frame
          n.resp     = cw;
          n.resp_tgl = ~r.resp_tgl;
          case (cw.opcode)
            rhc_pkg::OP_WIPER_WR: begin
              if (r.ctrl[`RH_C_UNPROT]) begin
                n.wiper = wiper_fit(cw.data);
              end
            end
            rhc_pkg::OP_WIPER_RD: begin
              n.resp = {6'h00, r.wiper};
            end
            rhc_pkg::OP_STORE: begin
              if (r.ctrl[`RH_C_PROG_EN] && r.last != `RH_MEM_LAST) begin
                n.we    = 1'b1;
                n.last  = r.last + `RH_MEM_FIRST;
                n.addr  = r.last + `RH_MEM_FIRST;
                n.wdata = r.wiper;
                n.ctrl[`RH_C_FUSE_OK] = 1'b0;
                n.cnt   = FUSE_LOAD;
                n.busy  = 1'b1;
                n.state = rhc_pkg::ST_FUSE;
              end else if (r.ctrl[`RH_C_PROG_EN]) begin
                n.ctrl[`RH_C_FUSE_OK] = 1'b0;
              end
            end
            rhc_pkg::OP_REFRESH: begin
              n.shutdown = 1'b0;
              n.state    = rhc_pkg::ST_BOOT;
            end
            rhc_pkg::OP_MEM_RD: begin
              // Keep the old word: the link must never see it change without a toggle
              n.resp       = r.resp;
              n.addr       = cw.data[`RH_MEM_AW-1:0];
              n.rd_refresh = 1'b0;
              n.resp_tgl   = r.resp_tgl;
              n.state      = rhc_pkg::ST_RD1;
            end
            rhc_pkg::OP_LAST_RD: begin
              n.resp = {10'h000, r.last};
            end
            rhc_pkg::OP_CTRL_WR: begin
              n.ctrl[`RH_C_CAL_DIS:`RH_C_PROG_EN] = cw.data[`RH_C_CAL_DIS:`RH_C_PROG_EN];
            end
            rhc_pkg::OP_CTRL_RD: begin
              n.resp = {12'h000, r.ctrl};
            end
            rhc_pkg::OP_SHUTDOWN: begin
              n.shutdown = cw.data[`RH_SD_BIT];
            end
            default: begin
            end
          endcase
        end
      end
      default: begin
        n.state = rhc_pkg::ST_BOOT;
      end
    endcase
    // A pin pulse caught while busy waits for idle; a new fall beats the clear
    if (pin_fall) begin
      n.pin_pend = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      r <= CORE_RST;
    end else if (ce) begin
      r <= n;
    end
  end

  always_comb begin
    ln        = l;
    ln.rsp_s1 = r.resp_tgl;
    ln.rsp_s2 = l.rsp_s1;
    ln.rsp_seen = l.rsp_s2;
    ln.ack_s1 = ~r.busy;
    ln.ack_s2 = l.ack_s1;
    if (l.rsp_s2 != l.rsp_seen) begin
      ln.resp_word = r.resp;
    end
    // No acknowledge means the frame never reaches the interpreter
    if (link_cmd_valid && l.ack_s2) begin
      ln.cmd_word = link_cmd_word;
      ln.cmd_tgl  = ~l.cmd_tgl;
    end
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      l <= LINK_RST;
    end else begin
      l <= ln;
    end
  end

  assign link_resp_word        = l.resp_word;
  assign link_ack_en           = l.ack_s2;
  assign wiper_register        = r.wiper;
  assign tolerance_cal_disable = r.ctrl[`RH_C_CAL_DIS];
  assign shutdown_active       = r.shutdown;
  assign control_flags         = {6'h00, r.ctrl};

  sequence s_refresh;
    cmd_go && ce && (cw.opcode == rhc_pkg::OP_REFRESH);
  endsequence

  sequence s_store_ok;
    cmd_go && ce && (cw.opcode == rhc_pkg::OP_STORE) && r.ctrl[`RH_C_PROG_EN] && (r.last != `RH_MEM_LAST);
  endsequence

  a_quarter_wiper: assert property (@(posedge clock) disable iff (!rst_n)
    cmd_go && ce && (cw == 16'h0500) && r.ctrl[`RH_C_UNPROT] && (WIPER_BITS == 10) |=> wiper_register == 10'h100)
    else $error("wiper not at quarter scale");

  a_ctrl_readback: assert property (@(posedge clock) disable iff (!rst_n)
    cmd_go && ce && (cw == 16'h2000) |=> r.resp == {6'h00, control_flags})
    else $error("control read data wrong");

  a_last_index: assert property (@(posedge clock) disable iff (!rst_n)
    cmd_go && ce && (cw == 16'h1800) |=> (r.resp[5:0] == r.last) && (r.resp[15:6] == 10'h000))
    else $error("last index read wrong");

  a_store_locked: assert property (@(posedge clock) disable iff (!rst_n)
    cmd_go && ce && (cw.opcode == rhc_pkg::OP_STORE) && !r.ctrl[`RH_C_PROG_EN] |=> $stable(r.last) && !r.busy)
    else $error("store taken while programming disabled");

  a_wiper_protect: assert property (@(posedge clock) disable iff (!rst_n)
    cmd_go && ce && (cw.opcode == rhc_pkg::OP_WIPER_WR) && !r.ctrl[`RH_C_UNPROT] |=> $stable(wiper_register))
    else $error("protected wiper changed");

  a_store_next: assert property (@(posedge clock) disable iff (!rst_n)
    s_store_ok |=> (r.last == $past(r.last) + `RH_MEM_FIRST) && r.we && (r.addr == r.last))
    else $error("store did not advance location");

  a_fuse_busy: assert property (@(posedge clock) disable iff (!rst_n)
    s_store_ok |=> (r.busy && !r.ctrl[`RH_C_FUSE_OK]) [*8])
    else $error("fuse cycle not held busy");

  a_fuse_flag: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(r.ctrl[`RH_C_FUSE_OK]) |-> $past(r.state) == rhc_pkg::ST_FUSE)
    else $error("success flag set outside fuse cycle");

  a_refresh_load: assert property (@(posedge clock) disable iff (!rst_n)
    s_refresh ##1 ce [*3] |=> (r.state == rhc_pkg::ST_IDLE) && !shutdown_active &&
      (wiper_register == ((r.last == '0) ? `RH_MIDSCALE : $past(mem_q))))
    else $error("refresh did not reload wiper");

  a_shutdown_set: assert property (@(posedge clock) disable iff (!rst_n)
    cmd_go && ce && (cw.opcode == rhc_pkg::OP_SHUTDOWN) |=> shutdown_active == $past(cw.data[`RH_SD_BIT]))
    else $error("shutdown state wrong");

  a_full_store: assert property (@(posedge clock) disable iff (!rst_n)
    cmd_go && ce && (cw.opcode == rhc_pkg::OP_STORE) && r.ctrl[`RH_C_PROG_EN] && (r.last == `RH_MEM_LAST)
      |=> !r.ctrl[`RH_C_FUSE_OK] && $stable(r.last) && $stable(wiper_register))
    else $error("store accepted with memory full");

  a_nack_drop: assert property (@(posedge link_clk) disable iff (!rst_n)
    !link_ack_en |=> $stable(l.cmd_tgl))
    else $error("frame accepted while not acknowledging");
endmodule

/* File: verification/rhc_link_master.sv */
// Link-side master model: one command word per frame, acknowledge polling before each frame.
// Assumes the link ports of rhc_core and a link clock that runs while frames are exchanged.
`timescale 1ns/1ps
module rhc_link_master (
  input  wire logic         link_clk,
  input  wire logic         link_ack_en,
  input  wire logic [15:0]  link_resp_word,
  output logic              link_cmd_valid,
  output rhc_pkg::rhc_cmd_s link_cmd_word
);
  initial begin
    link_cmd_valid = 1'b0;
    link_cmd_word  = 16'h0000;
  end

  // no_poll makes the master barge in while the device withholds acknowledge
  task automatic frame(input logic [15:0] word, input bit no_poll, output logic [15:0] resp);
    int n;
    n = 0;
    while (!no_poll && link_ack_en !== 1'b1 && n < 2000) begin
      @(posedge link_clk);
      #2;
      n++;
    end
    @(posedge link_clk);
    #2;
    resp           = link_resp_word;
    link_cmd_valid = 1'b1;
    link_cmd_word  = word;
    @(posedge link_clk);
    #2;
    link_cmd_valid = 1'b0;
    // Lines carry the inverted word between frames so a stale word can never pass for a command
    link_cmd_word  = ~word;
    repeat (12) @(posedge link_clk);
  endtask
endmodule

/* File: verification/rheostat_command_and_otp_control_bench.sv */
// Self-checking bench: command frames through the link master model, checks at the core ports.
// Assumes rhc_pkg, rhc_core and rhc_link_master are compiled first.
`timescale 1ns/1ps
module rheostat_command_and_otp_control_bench;
  logic              clock;
  logic              rst_n;
  logic              rst_pin_n;
  logic              link_clk;
  logic              link_cmd_valid;
  rhc_pkg::rhc_cmd_s link_cmd_word;
  logic [15:0]       link_resp_word;
  logic              link_ack_en;
  logic [9:0]        wiper_register;
  logic [9:0]        wiper8;
  logic              tolerance_cal_disable;
  logic              shutdown_active;
  logic [9:0]        control_flags;
  logic [15:0]       junk;
  int                fail_count;
  int                compares;

  rhc_core #(.WIPER_BITS(10), .FUSE_CYCLES(400)) dut (
    .clock(clock), .rst_n(rst_n), .ce(1'b1), .rst_pin_n(rst_pin_n), .link_clk(link_clk),
    .link_cmd_valid(link_cmd_valid), .link_cmd_word(link_cmd_word), .link_resp_word(link_resp_word),
    .link_ack_en(link_ack_en), .wiper_register(wiper_register),
    .tolerance_cal_disable(tolerance_cal_disable), .shutdown_active(shutdown_active),
    .control_flags(control_flags)
  );

  // The 256-position variant rides on the same frames; only its wiper is compared
  rhc_core #(.WIPER_BITS(8), .FUSE_CYCLES(400)) dut8 (
    .clock(clock), .rst_n(rst_n), .ce(1'b1), .rst_pin_n(rst_pin_n), .link_clk(link_clk),
    .link_cmd_valid(link_cmd_valid), .link_cmd_word(link_cmd_word), .link_resp_word(),
    .link_ack_en(), .wiper_register(wiper8), .tolerance_cal_disable(), .shutdown_active(),
    .control_flags()
  );

  rhc_link_master u_master (
    .link_clk(link_clk), .link_ack_en(link_ack_en), .link_resp_word(link_resp_word),
    .link_cmd_valid(link_cmd_valid), .link_cmd_word(link_cmd_word)
  );

  initial clock = 1'b0;
  always #10 clock = ~clock;

  // Link clock offset so its edges never line up with the core clock
  initial begin
    link_clk = 1'b0;
    #7;
    forever #40 link_clk = ~link_clk;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic xfer(input logic [15:0] word, input logic [15:0] exp, input bit chk);
    logic [15:0] resp;
    u_master.frame(word, 1'b0, resp);
    if (chk) check("response", resp, exp);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #1500000;
    fail_count++;
    complete_run();
  end

  initial begin
    rst_n      = 1'b0;
    rst_pin_n  = 1'b1;
    fail_count = 0;
    compares   = 0;
    repeat (8) @(posedge clock);
    check("wiper", {6'h00, wiper_register}, 16'h0200);
    check("flags", {6'h00, control_flags}, 16'h0000);
    #2;
    rst_n = 1'b1;
    repeat (10) @(posedge clock);
    check("wiper", {6'h00, wiper_register}, 16'h0200);
    check("ack", {15'h0000, link_ack_en}, 16'h0001);
    xfer(16'h0500, 16'h0000, 1'b0);
    check("wiper", {6'h00, wiper_register}, 16'h0200);
    xfer(16'h0c00, 16'h0500, 1'b1);
    xfer(16'h1800, 16'h0c00, 1'b1);
    xfer(16'h0000, 16'h0000, 1'b1);
    check("wiper", {6'h00, wiper_register}, 16'h0200);
    $display("test protect done");

    xfer(16'h1c03, 16'h0000, 1'b0);
    check("flags", {6'h00, control_flags}, 16'h0003);
    xfer(16'h0500, 16'h1c03, 1'b1);
    check("wiper", {6'h00, wiper_register}, 16'h0100);
    xfer(16'h0800, 16'h0500, 1'b1);
    xfer(16'h0c00, 16'h0100, 1'b1);
    check("ack", {15'h0000, link_ack_en}, 16'h0000);
    check("flags", {6'h00, control_flags}, 16'h0003);
    u_master.frame(16'h0401, 1'b1, junk);
    xfer(16'h1800, 16'h0c00, 1'b1);
    check("wiper", {6'h00, wiper_register}, 16'h0100);
    check("flags", {6'h00, control_flags}, 16'h000b);
    xfer(16'h0000, 16'h0001, 1'b1);
    xfer(16'h17c1, 16'h0000, 1'b1);
    xfer(16'h2000, 16'h0100, 1'b1);
    xfer(16'h0000, 16'h000b, 1'b1);
    $display("test store done");

    xfer(16'h1c07, 16'h0000, 1'b0);
    check("cal", {15'h0000, tolerance_cal_disable}, 16'h0001);
    check("flags", {6'h00, control_flags}, 16'h000f);
    xfer(16'h2401, 16'h0000, 1'b0);
    check("shutdown", {15'h0000, shutdown_active}, 16'h0001);
    xfer(16'h07ff, 16'h0000, 1'b0);
    check("narrow wiper", {6'h00, wiper8}, 16'h03fc);
    xfer(16'h0800, 16'h0000, 1'b0);
    xfer(16'h0000, 16'h03ff, 1'b1);
    xfer(16'h1000, 16'h0000, 1'b0);
    check("wiper", {6'h00, wiper_register}, 16'h0100);
    check("shutdown", {15'h0000, shutdown_active}, 16'h0000);
    xfer(16'h2401, 16'h0000, 1'b0);
    xfer(16'h2400, 16'h0000, 1'b0);
    check("shutdown", {15'h0000, shutdown_active}, 16'h0000);
    xfer(16'h2401, 16'h0000, 1'b0);
    check("shutdown", {15'h0000, shutdown_active}, 16'h0001);
    xfer(16'h0477, 16'h0000, 1'b0);
    check("wiper", {6'h00, wiper_register}, 16'h0077);
    @(posedge clock);
    #2;
    rst_pin_n = 1'b0;
    repeat (4) @(posedge clock);
    #2;
    rst_pin_n = 1'b1;
    repeat (12) @(posedge clock);
    check("wiper", {6'h00, wiper_register}, 16'h0100);
    check("shutdown", {15'h0000, shutdown_active}, 16'h0000);
    check("flags", {6'h00, control_flags}, 16'h000f);
    $display("test shutdown done");

    for (int i = 2; i <= 50; i++) begin
      xfer(16'h0400 | 16'(i), 16'h0000, 1'b0);
      xfer(16'h0c00, 16'h0000, 1'b0);
    end
    xfer(16'h1800, 16'h0000, 1'b0);
    xfer(16'h0000, 16'h0032, 1'b1);
    xfer(16'h1432, 16'h0000, 1'b0);
    xfer(16'h0000, 16'h0032, 1'b1);
    xfer(16'h0455, 16'h0000, 1'b0);
    xfer(16'h0c00, 16'h0000, 1'b0);
    xfer(16'h1800, 16'h0000, 1'b0);
    check("flags", {6'h00, control_flags}, 16'h0007);
    check("wiper", {6'h00, wiper_register}, 16'h0055);
    xfer(16'h0000, 16'h0032, 1'b1);
    xfer(16'h1000, 16'h0000, 1'b0);
    check("wiper", {6'h00, wiper_register}, 16'h0032);
    check("narrow wiper", {6'h00, wiper8}, 16'h0030);
    $display("test fill done");
    complete_run();
  end
endmodule
